// *** hw/dosc_defines.vh ***
// Constants for the drive on/off state control block.
// Assumes inclusion by bare name from the top design file and the bench.
`ifndef DOSC_DEFINES_VH
`define DOSC_DEFINES_VH

// Register byte addresses on the AHB-Lite slave
`define DOSC_ADDR_CTRL 8'h00
`define DOSC_ADDR_CONFIG 8'h04
`define DOSC_ADDR_SETPOINT 8'h08
`define DOSC_ADDR_JOG_SP0 8'h0c
`define DOSC_ADDR_JOG_SP1 8'h10
`define DOSC_ADDR_RAMP_STEP 8'h14
`define DOSC_ADDR_QUICK_STEP 8'h18
`define DOSC_ADDR_STATUS 8'h1c

// Command word bit positions (control word and digital input group)
`define DOSC_CMD_ON 0
`define DOSC_CMD_COAST 1
`define DOSC_CMD_QUICK 2
`define DOSC_CMD_RUN_EN 3
`define DOSC_CMD_JOG0 4
`define DOSC_CMD_JOG1 5
`define DOSC_CMD_W 6

// Configuration bit positions and reset values
`define DOSC_CFG_AUTO_START 0
`define DOSC_CFG_RUN_EN_AUTO 1
`define DOSC_CFG_SET_LO 2
`define DOSC_CFG_SET_HI 3
`define DOSC_CFG_RESET 4'h2
`define DOSC_CTRL_RESET 6'h00
`define DOSC_SETPOINT_RESET 16'h0000
`define DOSC_JOG_SP0_RESET 16'h0100
`define DOSC_JOG_SP1_RESET 16'hff00
`define DOSC_RAMP_STEP_RESET 16'h0001
`define DOSC_QUICK_STEP_RESET 16'h0004

// Control states
`define DOSC_ST_POWERUP 3'h0
`define DOSC_ST_INHIBIT 3'h1
`define DOSC_ST_READY 3'h2
`define DOSC_ST_WAIT_EN 3'h3
`define DOSC_ST_OPERATING 3'h4
`define DOSC_ST_RAMP_STOP 3'h5
`define DOSC_ST_QUICK_STOP 3'h6
`define DOSC_ST_JOG 3'h7

// Timing
`define DOSC_CLK_KHZ 40000
`define DOSC_SWITCH_TIME_US 4000
`define DOSC_POWERUP_SETTLE 2'h3

`endif

// *** hw/dosc_ramp.v ***
// Ramp generator: moves a signed speed toward a target by a fixed step each cycle.
// Assumes step is an unsigned magnitude; zero_now forces the speed to zero at once.
`timescale 1ns/1ps
`default_nettype none
module dosc_ramp (
  input wire ref_clk,
  input wire srst,
  input wire zero_now,
  input wire [15:0] target,
  input wire [15:0] step,
  output reg [15:0] speed_q,
  output reg standstill_q
);
  wire signed [16:0] diff;
  wire signed [16:0] step_s;
  wire [16:0] up;
  wire [16:0] down;
  reg [15:0] speed_d;

  assign diff = $signed({target[15], target}) - $signed({speed_q[15], speed_q});
  assign step_s = $signed({1'b0, step});
  assign up = {speed_q[15], speed_q} + {1'b0, step};
  assign down = {speed_q[15], speed_q} - {1'b0, step};

  always @* begin
    if (zero_now) begin
      speed_d = 16'h0000;
    end else if (diff > step_s) begin
      speed_d = up[15:0];
    end else if (diff < -step_s) begin
      speed_d = down[15:0];
    end else begin
      speed_d = target;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      speed_q <= 16'h0000;
      standstill_q <= 1'b1;
    end else begin
      speed_q <= speed_d;
      standstill_q <= (speed_d == 16'h0000);
    end
  end
endmodule // dosc_ramp
`default_nettype wire

// *** hw/dosc_sync2.v ***
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module dosc_sync2 #(
  parameter W = 6
) (
  input wire ref_clk,
  input wire srst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_q
);
  reg [W-1:0] meta_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule // dosc_sync2
`default_nettype wire

// *** hw/dosc_top.v ***
// Drive on/off state control: switch-on sequencing, three stop commands,
// jogging and command setting set selection, with an AHB-Lite register slave.
// Assumes a single ref_clk, digital inputs asynchronous to it, one AHB master.
//
// Summary of operation
// - After power-up settle in ready to switch on
// - Switch-on from ready leads to energised operation
// - Ramp stop: decelerate, de-energise, back to ready
// - Coast stop de-energises at once, no ramp
// - Quick stop decelerates with quick step, then off
// - Switch-on command ignored while switch-on inhibited
// - Switch-on active at power-up means inhibited
// - Auto start accepts switch-on active at power-up
// - Coast or quick stop leads to inhibited
// - Energise only by way of ready to switch on
// - Wait for run enable before operating
// - Run enable automatic in default configuration
// - Motor stays energised while operating
// - Ramp stopping uses the normal ramp step
// - Quick stopping uses the quick ramp step
// - Jog input switches motor, ramps to jog setpoint
// - Two independent jog setpoints
// - Jog shares the normal ramp generator
// - Jog accepted only when ready, else ignored
// - Command sets: fieldbus word or digital inputs
// - Two bits select set; active set readable
// - Set switchover takes about four milliseconds
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dosc_defines.vh"
module dosc_top #(
  parameter SWITCH_CYCLES = (`DOSC_SWITCH_TIME_US * `DOSC_CLK_KHZ) / 1000
) (
  input wire ref_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire di_on,
  input wire di_coast_stop,
  input wire di_quick_stop,
  input wire di_run_enable,
  input wire di_jog0,
  input wire di_jog1,
  output reg motor_energised_q,
  output wire [15:0] motor_speed,
  output reg [2:0] drive_state_q,
  output reg [1:0] active_set_q
);
  localparam integer SWITCH_LAST_I = SWITCH_CYCLES - 1;
  localparam [17:0] SWITCH_LAST = SWITCH_LAST_I[17:0];

  // Register file
  reg [5:0] ctrl_q;
  reg [3:0] cfg_q;
  reg [15:0] setpoint_q;
  reg [15:0] jog_sp0_q;
  reg [15:0] jog_sp1_q;
  reg [15:0] ramp_step_q;
  reg [15:0] quick_step_q;

  // Bus data-phase capture
  reg wr_pend_q;
  reg [7:0] wr_addr_q;

  // Set switchover
  reg [1:0] req_set_q;
  reg [17:0] switch_cnt_q;
  reg switch_busy_q;

  // Control machine
  reg [2:0] state_d;
  reg [1:0] pwr_cnt_q;
  reg [15:0] target;
  reg [15:0] step;
  reg zero_now;
  reg [31:0] rd_mux;

  wire [5:0] di_sync;
  wire [15:0] speed;
  wire standstill;
  wire [5:0] cmd;
  wire addr_ok;
  wire on_cmd;
  wire coast_cmd;
  wire quick_cmd;
  wire ramp_stop_cmd;
  wire run_enable;
  wire jog_any;
  wire [15:0] jog_sp;

  dosc_sync2 #(
    .W(`DOSC_CMD_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({di_jog1, di_jog0, di_run_enable, di_quick_stop, di_coast_stop, di_on}),
    .sync_q(di_sync)
  );

  // Odd sets take the digital inputs, even sets the fieldbus control word
  assign cmd = active_set_q[0] ? di_sync : ctrl_q;

  assign on_cmd = cmd[`DOSC_CMD_ON];
  assign coast_cmd = cmd[`DOSC_CMD_COAST];
  assign quick_cmd = cmd[`DOSC_CMD_QUICK] & ~coast_cmd;
  assign ramp_stop_cmd = ~on_cmd & ~coast_cmd & ~quick_cmd;
  assign run_enable = cmd[`DOSC_CMD_RUN_EN] | cfg_q[`DOSC_CFG_RUN_EN_AUTO];
  assign jog_any = cmd[`DOSC_CMD_JOG0] | cmd[`DOSC_CMD_JOG1];
  assign jog_sp = cmd[`DOSC_CMD_JOG0] ? jog_sp0_q : jog_sp1_q;

  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_ok = hsel & htrans[1] & hready;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `DOSC_ADDR_CTRL: rd_mux = {26'h000_0000, ctrl_q};
      `DOSC_ADDR_CONFIG: rd_mux = {28'h000_0000, cfg_q};
      `DOSC_ADDR_SETPOINT: rd_mux = {16'h0000, setpoint_q};
      `DOSC_ADDR_JOG_SP0: rd_mux = {16'h0000, jog_sp0_q};
      `DOSC_ADDR_JOG_SP1: rd_mux = {16'h0000, jog_sp1_q};
      `DOSC_ADDR_RAMP_STEP: rd_mux = {16'h0000, ramp_step_q};
      `DOSC_ADDR_QUICK_STEP: rd_mux = {16'h0000, quick_step_q};
      `DOSC_ADDR_STATUS: begin
        rd_mux = {speed, 9'h000, switch_busy_q, active_set_q, motor_energised_q,
                  drive_state_q};
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
      end
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= `DOSC_CTRL_RESET;
      cfg_q <= `DOSC_CFG_RESET;
      setpoint_q <= `DOSC_SETPOINT_RESET;
      jog_sp0_q <= `DOSC_JOG_SP0_RESET;
      jog_sp1_q <= `DOSC_JOG_SP1_RESET;
      ramp_step_q <= `DOSC_RAMP_STEP_RESET;
      quick_step_q <= `DOSC_QUICK_STEP_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `DOSC_ADDR_CTRL: ctrl_q <= hwdata[5:0];
        `DOSC_ADDR_CONFIG: cfg_q <= hwdata[3:0];
        `DOSC_ADDR_SETPOINT: setpoint_q <= hwdata[15:0];
        `DOSC_ADDR_JOG_SP0: jog_sp0_q <= hwdata[15:0];
        `DOSC_ADDR_JOG_SP1: jog_sp1_q <= hwdata[15:0];
        `DOSC_ADDR_RAMP_STEP: ramp_step_q <= hwdata[15:0];
        `DOSC_ADDR_QUICK_STEP: quick_step_q <= hwdata[15:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Command set switchover: the new set becomes active after the delay
  always @(posedge ref_clk) begin
    if (srst) begin
      req_set_q <= 2'h0;
      active_set_q <= 2'h0;
      switch_cnt_q <= 18'h00000;
      switch_busy_q <= 1'b0;
    end else begin
      req_set_q <= cfg_q[`DOSC_CFG_SET_HI:`DOSC_CFG_SET_LO];
      if (req_set_q != active_set_q) begin
        if (!switch_busy_q) begin
          switch_busy_q <= 1'b1;
          switch_cnt_q <= 18'h00000;
        end else if (switch_cnt_q >= SWITCH_LAST) begin
          active_set_q <= req_set_q;
          switch_busy_q <= 1'b0;
        end else begin
          switch_cnt_q <= switch_cnt_q + 18'h00001;
        end
      end else begin
        switch_busy_q <= 1'b0;
      end
    end
  end

  // Next state
  always @* begin
    state_d = drive_state_q;
    case (drive_state_q)
      `DOSC_ST_POWERUP: begin
        if (pwr_cnt_q == `DOSC_POWERUP_SETTLE) begin
          if (on_cmd && !cfg_q[`DOSC_CFG_AUTO_START]) begin
            state_d = `DOSC_ST_INHIBIT;
          end else if (coast_cmd || quick_cmd) begin
            state_d = `DOSC_ST_INHIBIT;
          end else begin
            state_d = `DOSC_ST_READY;
          end
        end
      end
      `DOSC_ST_INHIBIT: begin
        // Leaves only once switch-on is withdrawn and no stop is pending
        if (!on_cmd && !coast_cmd && !quick_cmd) begin
          state_d = `DOSC_ST_READY;
        end
      end
      `DOSC_ST_READY: begin
        if (coast_cmd || quick_cmd) begin
          state_d = `DOSC_ST_INHIBIT;
        end else if (on_cmd) begin
          state_d = `DOSC_ST_WAIT_EN;
        end else if (jog_any) begin
          state_d = `DOSC_ST_JOG;
        end
      end
      `DOSC_ST_WAIT_EN: begin
        if (coast_cmd || quick_cmd) begin
          state_d = `DOSC_ST_INHIBIT;
        end else if (!on_cmd) begin
          state_d = `DOSC_ST_READY;
        end else if (run_enable) begin
          state_d = `DOSC_ST_OPERATING;
        end
      end
      `DOSC_ST_OPERATING: begin
        // Jog requests are not looked at here
        if (coast_cmd) begin
          state_d = `DOSC_ST_INHIBIT;
        end else if (quick_cmd) begin
          state_d = `DOSC_ST_QUICK_STOP;
        end else if (ramp_stop_cmd) begin
          state_d = `DOSC_ST_RAMP_STOP;
        end
      end
      `DOSC_ST_RAMP_STOP: begin
        if (coast_cmd) begin
          state_d = `DOSC_ST_INHIBIT;
        end else if (quick_cmd) begin
          state_d = `DOSC_ST_QUICK_STOP;
        end else if (standstill) begin
          state_d = `DOSC_ST_READY;
        end
      end
      `DOSC_ST_QUICK_STOP: begin
        if (coast_cmd || standstill) begin
          state_d = `DOSC_ST_INHIBIT;
        end
      end
      `DOSC_ST_JOG: begin
        if (coast_cmd) begin
          state_d = `DOSC_ST_INHIBIT;
        end else if (quick_cmd) begin
          state_d = `DOSC_ST_QUICK_STOP;
        end else if (!jog_any && standstill) begin
          state_d = `DOSC_ST_READY;
        end
      end
      default: state_d = `DOSC_ST_INHIBIT;
    endcase
  end

  // Ramp target and rate follow the next state, so speed drops with energised
  always @* begin
    target = 16'h0000;
    step = ramp_step_q;
    zero_now = 1'b1;
    case (state_d)
      `DOSC_ST_OPERATING: begin
        target = setpoint_q;
        zero_now = 1'b0;
      end
      `DOSC_ST_RAMP_STOP: begin
        step = ramp_step_q;
        zero_now = 1'b0;
      end
      `DOSC_ST_QUICK_STOP: begin
        step = quick_step_q;
        zero_now = 1'b0;
      end
      `DOSC_ST_JOG: begin
        target = jog_any ? jog_sp : 16'h0000;
        step = ramp_step_q;
        zero_now = 1'b0;
      end
      default: zero_now = 1'b1;
    endcase
  end

  dosc_ramp u_ramp (
    .ref_clk(ref_clk),
    .srst(srst),
    .zero_now(zero_now),
    .target(target),
    .step(step),
    .speed_q(speed),
    .standstill_q(standstill)
  );

  assign motor_speed = speed;

  always @(posedge ref_clk) begin
    if (srst) begin
      drive_state_q <= `DOSC_ST_POWERUP;
      pwr_cnt_q <= 2'h0;
      motor_energised_q <= 1'b0;
    end else begin
      drive_state_q <= state_d;
      if (pwr_cnt_q != `DOSC_POWERUP_SETTLE) begin
        pwr_cnt_q <= pwr_cnt_q + 2'h1;
      end
      // Energised in operating, during both braking states and while jogging
      motor_energised_q <= (state_d == `DOSC_ST_OPERATING) ||
                           (state_d == `DOSC_ST_RAMP_STOP) ||
                           (state_d == `DOSC_ST_QUICK_STOP) ||
                           (state_d == `DOSC_ST_JOG);
    end
  end
endmodule // dosc_top
`default_nettype wire

// *** sim/dosc_ctrl_model.sv ***
// Digital-input side of the higher-level controller.
// Assumes cmd bits in command word order; lines change just after an edge.
`timescale 1ns/1ps
`default_nettype none
module dosc_ctrl_model (
  input wire ref_clk,
  input wire [5:0] cmd,
  output logic [5:0] di_q
);
  initial di_q = 6'h00;
  always @(posedge ref_clk) begin
    di_q <= cmd;
  end
endmodule // dosc_ctrl_model
`default_nettype wire

// *** sim/dosc_top_assertions.sv ***
// Checker for the on/off state control outputs of dosc_top.
// Assumes a bind to dosc_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dosc_top_assertions (
  input wire ref_clk,
  input wire srst,
  input wire hreadyout,
  input wire hresp,
  input wire motor_energised_q,
  input wire [15:0] motor_speed,
  input wire [2:0] drive_state_q,
  input wire [1:0] active_set_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [2:0] s = drive_state_q;
  wire [15:0] v = motor_speed;
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY");
  a_energ_state: assert property ((s >= 3'h4) == motor_energised_q)
    else $error("energised does not match state");
  a_run_entry: assert property ($changed(s) && s == 3'h4 |-> $past(s) == 3'h3)
    else $error("operating entered without run enable wait");
  a_wait_entry: assert property ($changed(s) && s == 3'h3 |-> $past(s) == 3'h2)
    else $error("switch-on not from ready");
  a_jog_entry: assert property ($changed(s) && s == 3'h7 |-> $past(s) == 3'h2)
    else $error("jog entered from a state other than ready");
  a_coast_off: assert property (s == 3'h1 && $past(s) == 3'h4 |-> v == 16'h0 && !motor_energised_q)
    else $error("coast stop left motor running");
  a_ramp_done: assert property (s == 3'h2 && $past(s) == 3'h5 |-> v == 16'h0)
    else $error("ramp stop ended above standstill");
  a_quick_done: assert property (s == 3'h1 && $past(s) == 3'h6 |-> v == 16'h0)
    else $error("quick stop ended above standstill");
  a_ramp_step: assert property (s == 3'h5 && $past(s) == 3'h5 && $past(s, 2) == 3'h5
    && $past(v) > 16'h0 && $past(v) < 16'h8000 |-> v == $past(v) - 16'h1)
    else $error("ramp stop step wrong");
  a_quick_step: assert property (s == 3'h6 && $past(s) == 3'h6 && $past(s, 2) == 3'h6
    && $past(v) > 16'h3 && $past(v) < 16'h8000 |-> v == $past(v) - 16'h4)
    else $error("quick stop step wrong");
  c_quick: cover property (s == 3'h6);
  c_jog: cover property (s == 3'h7);
  c_set_one: cover property (active_set_q == 2'h1);
endmodule // dosc_top_assertions
`default_nettype wire

// *** sim/dosc_top_tb.sv ***
// Self-checking bench for dosc_top over AHB-Lite and digital inputs.
// Assumes dosc_defines.vh on the include path and a short switchover count.
`timescale 1ns/1ps
`default_nettype none
`include "dosc_defines.vh"
module dosc_top_tb;
  localparam int SW = 8;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] cmd = 6'h00;
  wire [5:0] di_q;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire motor_energised_q;
  wire [15:0] motor_speed;
  wire [2:0] drive_state_q;
  wire [1:0] active_set_q;
  int n_fail = 0;
  int compares = 0;
  int i;
  always #12.5 ref_clk = ~ref_clk;
  dosc_top #(.SWITCH_CYCLES(SW)) u_dosc_top (.ref_clk(ref_clk), .srst(srst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .di_on(di_q[0]), .di_coast_stop(di_q[1]), .di_quick_stop(di_q[2]),
    .di_run_enable(di_q[3]), .di_jog0(di_q[4]), .di_jog1(di_q[5]),
    .motor_energised_q(motor_energised_q), .motor_speed(motor_speed),
    .drive_state_q(drive_state_q), .active_set_q(active_set_q));
  dosc_ctrl_model u_dosc_ctrl_model (.ref_clk(ref_clk), .cmd(cmd), .di_q(di_q));
  task test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk("hrdata", e, hrdata);
  endtask
  task ctl(input logic [31:0] d);
    xfer(`DOSC_ADDR_CTRL, 1'b1, d);
  endtask
  task wst(input logic [2:0] s);
    for (i = 0; i < 2000 && drive_state_q !== s; i++) @(posedge ref_clk);
    chk("state", 32'(s), 32'(drive_state_q));
  endtask
  task wsp(input logic [15:0] v);
    for (i = 0; i < 2000 && motor_speed !== v; i++) @(posedge ref_clk);
    chk("speed", 32'(v), 32'(motor_speed));
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    ctl(32'h1);
    wst(3'h1);
    repeat (20) @(posedge ref_clk);
    chk("state", 32'h1, 32'(drive_state_q));
    ctl(32'h0);
    wst(3'h2);
    rd(`DOSC_ADDR_CONFIG, 32'h2);
    rd(`DOSC_ADDR_JOG_SP0, 32'h100);
    rd(8'h40, 32'h0);
    xfer(`DOSC_ADDR_SETPOINT, 1'b1, 32'h40);
    ctl(32'h1);
    wst(3'h4);
    chk("energised", 32'h1, 32'(motor_energised_q));
    wsp(16'h40);
    ctl(32'h0);
    wst(3'h5);
    wst(3'h2);
    chk("energised", 32'h0, 32'(motor_energised_q));
    ctl(32'h1);
    wsp(16'h40);
    ctl(32'h5);
    wst(3'h6);
    wst(3'h1);
    ctl(32'h0);
    wst(3'h2);
    ctl(32'h1);
    wsp(16'h40);
    ctl(32'h7);
    repeat (3) @(posedge ref_clk);
    chk("state", 32'h1, 32'(drive_state_q));
    chk("speed", 32'h0, 32'(motor_speed));
    ctl(32'h0);
    wst(3'h2);
    xfer(`DOSC_ADDR_CONFIG, 1'b1, 32'h0);
    ctl(32'h1);
    repeat (12) @(posedge ref_clk);
    chk("state", 32'h3, 32'(drive_state_q));
    ctl(32'h9);
    wst(3'h4);
    ctl(32'h19);
    repeat (5) @(posedge ref_clk);
    chk("state", 32'h4, 32'(drive_state_q));
    ctl(32'h0);
    wst(3'h2);
    xfer(`DOSC_ADDR_CONFIG, 1'b1, 32'h2);
    ctl(32'h20);
    wst(3'h7);
    wsp(16'hff00);
    ctl(32'h0);
    wst(3'h2);
    ctl(32'h10);
    wsp(16'h0100);
    ctl(32'h0);
    wst(3'h2);
    xfer(`DOSC_ADDR_CONFIG, 1'b1, 32'h6);
    for (i = 0; i < 100 && active_set_q !== 2'h1; i++) @(posedge ref_clk);
    chk("switch time", 32'h1, 32'(i >= SW && i <= SW + 4));
    rd(`DOSC_ADDR_STATUS, 32'h12);
    cmd <= 6'h01;
    wst(3'h4);
    cmd <= 6'h00;
    wst(3'h2);
    srst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    xfer(`DOSC_ADDR_CONFIG, 1'b1, 32'h3);
    ctl(32'h1);
    wst(3'h4);
    test_done();
  end
endmodule // dosc_top_tb
bind dosc_top dosc_top_assertions u_dosc_top_assertions (.ref_clk(ref_clk), .srst(srst),
  .hreadyout(hreadyout), .hresp(hresp), .motor_energised_q(motor_energised_q),
  .motor_speed(motor_speed), .drive_state_q(drive_state_q), .active_set_q(active_set_q));
`default_nettype wire
